// >>> rtl/pci_bus_signal_layer.sv
// pin signalling of the pci bus: parity, error lines, handshake pins, request/grant/reset roles
//
// Function
// - even parity over all 32 address/data bits
// - master drives parity on address/writes, target on reads
// - receiver flags parity error two clocks after data
// - internal arbiter: all four requests are inputs
// - external arbiter: request zero ours, others high
// - satellite: request one is config select input
// - host drives bus reset; satellite reset warm-resets
// - system error on address/special parity errors
// - target asserts stop to end transaction early
// - target asserts target ready to complete data
// - master asserts initiator ready for data item
// - frame starts transaction, released on last data
// - internal arbiter grants the selected agent
`timescale 1ns/100ps
module pci_bus_signal_layer
	import pci_sig_pkg::*;
(
	input  wire logic            clk,
	input  wire logic            srst,
	// straps
	input  wire logic            hostModeStrap,       // high selects host role
	input  wire logic            intArbiterStrap,     // high selects the on-chip arbiter
	// bus pins
	input  wire logic            busClk,              // bus clock, sampled
	input  wire logic [AD_W-1:0] busAddrDataIn,
	output logic      [AD_W-1:0] busAddrDataOut,
	output logic                 busAddrDataOe,
	input  wire logic            busParityIn,
	output logic                 busParityOut,
	output logic                 busParityOe,
	input  wire logic            parityErrorNIn,
	output logic                 parityErrorNOut,
	output logic                 parityErrorNOe,
	input  wire logic [REQ_W-1:0] busRequestNIn,
	output logic      [REQ_W-1:0] busRequestNOut,
	output logic      [REQ_W-1:0] busRequestNOe,
	input  wire logic [REQ_W-1:0] busGrantNIn,
	output logic      [REQ_W-1:0] busGrantNOut,
	output logic      [REQ_W-1:0] busGrantNOe,
	input  wire logic            busResetNIn,
	output logic                 busResetNOut,
	output logic                 busResetNOe,
	input  wire logic            systemErrorNIn,
	output logic                 systemErrorNOut,
	output logic                 systemErrorNOe,
	input  wire logic            targetStopNIn,
	output logic                 targetStopNOut,
	output logic                 targetStopNOe,
	input  wire logic            targetReadyNIn,
	output logic                 targetReadyNOut,
	output logic                 targetReadyNOe,
	input  wire logic            initiatorReadyNIn,
	output logic                 initiatorReadyNOut,
	output logic                 initiatorReadyNOe,
	input  wire logic            transactionFrameNIn,
	output logic                 transactionFrameNOut,
	output logic                 transactionFrameNOe,
	input  wire logic            exclusiveLockNIn,
	// user side, taken at each bus edge
	input  wire logic [AD_W-1:0] userAdOut,           // word to drive next bus clock
	input  wire logic            userAdDrive,         // device drives address or write/read data
	input  wire logic            userRxData,          // device receives a data phase at this edge
	input  wire logic            userAddrCheck,       // device as target checks this address phase
	input  wire logic            userSpecialCycle,    // received data belongs to a special cycle
	input  wire logic            userSysErr,          // other system error
	input  wire logic            userMasterActive,    // device owns frame and initiator ready
	input  wire logic            userFrameAssert,
	input  wire logic            userIrdyAssert,
	input  wire logic            userTargetActive,    // device owns target ready and stop
	input  wire logic            userTrdyAssert,
	input  wire logic            userStopAssert,
	input  wire logic            userBusReq,          // device wants the bus
	input  wire logic            userBusReset,        // host asks for a bus reset
	// user side status
	output logic                 busEdge,             // pulse after each bus clock rising edge
	output logic      [AD_W-1:0] rxAddrData,          // word sampled at the last edge
	output logic                 parityErrorSeen,     // pulse, parity error driven by the device
	output logic                 systemErrorSeen,     // pulse, system error driven by the device
	output logic                 warmReset,           // pulse, bus reset asserted in satellite role
	output logic                 ownGrant,            // device holds the bus grant
	output logic                 configSelect,        // config chip select, satellite role
	output logic                 lockActive,          // an exclusive operation is running
	output bus_mode_e            busMode              // role captured at reset
);

	localparam int SYNC_W = AD_W + 2 * REQ_W + 12; // all pins that are sampled

	// every flip-flop of the block
	typedef struct packed {
		bus_mode_e        mode;       // role, changes only under reset
		arb_state_e       arb;        // internal arbiter state
		logic [1:0]       holder;     // agent that holds the grant
		logic             clkPrev, rstPrev, edgeOut; // pins one cycle ago, bus edge pulse
		logic [AD_W-1:0]  rxWord, adOut;             // word received, word driven
		logic             adOe, parOut, parOe, perrOut, perrOe, serrOut, serrOe;
		logic             stopOut, stopOe, trdyOut, trdyOe, irdyOut, irdyOe, frameOut, frameOe;
		logic [REQ_W-1:0] reqOut, reqOe, gntOut, gntOe;
		logic             rstOut, rstOe, perrSeen, serrSeen, warm, own, cfgSel, lock; // status
	} top_s;

	top_s st_r;  // registered state
	top_s st_nxt; // next state

	// synchronised pins
	logic [SYNC_W-1:0] syncIn;
	logic [SYNC_W-1:0] syncOut;
	logic              sClk, sPar, sPerr, sRst, sSerr, sStop, sTrdy, sIrdy, sFrame, sLock, sHost, sArb;
	logic [AD_W-1:0]   sAd;
	logic [REQ_W-1:0]  sReq, sGnt;
	logic              edgeNow;   // rising bus clock found this cycle
	logic              perrDue;   // from the checker
	logic              serrDue;   // from the checker
	logic              busIdle;   // frame and initiator ready both high
	logic [1:0]        winner;    // lowest asserted request
	logic              anyReq;    // some external agent requests

	assign syncIn = {busClk, busAddrDataIn, busParityIn, parityErrorNIn, busRequestNIn, busGrantNIn,
		busResetNIn, systemErrorNIn, targetStopNIn, targetReadyNIn, initiatorReadyNIn,
		transactionFrameNIn, exclusiveLockNIn, hostModeStrap, intArbiterStrap};

	// every pin and strap is asynchronous to clk
	pin_sync #(
		.W       (SYNC_W),
		.RST_VAL ({SYNC_W{PIN_IDLE}})
	) pinSyncInst (
		.clk     (clk),
		.srst    (srst),
		.pinIn   (syncIn),
		.pinSync (syncOut)
	);

	assign {sClk, sAd, sPar, sPerr, sReq, sGnt, sRst, sSerr, sStop, sTrdy, sIrdy, sFrame, sLock,
		sHost, sArb} = syncOut;

	assign edgeNow = sClk && !st_r.clkPrev;
	assign busIdle = sFrame && sIrdy;

	// parity of received phases
	parity_check #(
		.DELAY      (PERR_DELAY_EDGES)
	) parityCheckInst (
		.clk        (clk),
		.srst       (srst),
		.busEdge    (edgeNow),
		.rxAddrData (sAd),
		.rxParity   (sPar),
		.capture    (userRxData || userAddrCheck),
		.sysClass   (userAddrCheck || userSpecialCycle),
		.perrDue    (perrDue),
		.serrDue    (serrDue)
	);

	// fixed priority pick; index 0 wins
	always_comb begin
		winner = 2'h0;
		anyReq = 1'b0;
		for (int i = REQ_W - 1; i >= 0; i--) begin
			if (sReq[i] == PIN_ACTIVE) begin
				winner = 2'(i);
				anyReq = 1'b1;
			end
		end
	end

	// next state of all pins and status
	always_comb begin
		st_nxt         = st_r;
		st_nxt.clkPrev = sClk;
		st_nxt.rstPrev = sRst;
		st_nxt.edgeOut = edgeNow;
		st_nxt.warm    = 1'b0;
		st_nxt.perrSeen = 1'b0;
		st_nxt.serrSeen = 1'b0;
		// a falling bus reset in satellite role resets the device, no bus clock needed
		if (st_r.mode == MODE_SATELLITE && st_r.rstPrev && !sRst) begin
			st_nxt.warm = 1'b1;
		end
		if (edgeNow) begin
			st_nxt.rxWord = sAd;
			st_nxt.lock   = (sLock == PIN_ACTIVE);
			// address or data goes out now, its parity one clock later from whoever drove it
			st_nxt.adOut  = userAdOut;
			st_nxt.adOe   = userAdDrive;
			st_nxt.parOut = ^st_r.adOut;
			st_nxt.parOe  = st_r.adOe;
			// parity error: low one clock, then driven high one clock before release
			st_nxt.perrOut  = perrDue ? PIN_ACTIVE : PIN_IDLE;
			st_nxt.perrOe   = perrDue || (st_r.perrOe && st_r.perrOut == PIN_ACTIVE);
			st_nxt.perrSeen = perrDue;
			// system error is open drain, the pull-up returns it high
			st_nxt.serrOut  = (serrDue || userSysErr) ? PIN_ACTIVE : PIN_IDLE;
			st_nxt.serrOe   = serrDue || userSysErr;
			st_nxt.serrSeen = serrDue || userSysErr;
			// shared handshake pins left low by their owner are driven high for one clock after it lets go
			st_nxt.frameOut = (userMasterActive && userFrameAssert) ? PIN_ACTIVE : PIN_IDLE;
			st_nxt.frameOe  = userMasterActive || (st_r.frameOe && st_r.frameOut == PIN_ACTIVE);
			st_nxt.irdyOut  = (userMasterActive && userIrdyAssert) ? PIN_ACTIVE : PIN_IDLE;
			st_nxt.irdyOe   = userMasterActive || (st_r.irdyOe && st_r.irdyOut == PIN_ACTIVE);
			st_nxt.trdyOut  = (userTargetActive && userTrdyAssert) ? PIN_ACTIVE : PIN_IDLE;
			st_nxt.trdyOe   = userTargetActive || (st_r.trdyOe && st_r.trdyOut == PIN_ACTIVE);
			st_nxt.stopOut  = (userTargetActive && userStopAssert) ? PIN_ACTIVE : PIN_IDLE;
			st_nxt.stopOe   = userTargetActive || (st_r.stopOe && st_r.stopOut == PIN_ACTIVE);
			// host holds the bus in reset while asked; satellite only listens
			st_nxt.rstOut = userBusReset ? PIN_ACTIVE : PIN_IDLE;
			st_nxt.rstOe  = (st_r.mode != MODE_SATELLITE);
			// request and grant pin roles follow the captured mode
			unique case (st_r.mode)
				MODE_HOST_INT: begin
					st_nxt.reqOe  = '0;
					st_nxt.reqOut = '1;
					st_nxt.gntOe  = '1;
					st_nxt.cfgSel = 1'b0;
					// one grant at a time, and a turnaround clock with no grant between owners
					unique case (st_r.arb)
						ARB_IDLE: begin
							if (busIdle && userBusReq) begin
								st_nxt.own = 1'b1;
								st_nxt.arb = ARB_OWN;
							end else if (busIdle && anyReq) begin
								st_nxt.gntOut         = '1;
								st_nxt.gntOut[winner] = PIN_ACTIVE;
								st_nxt.holder         = winner;
								st_nxt.arb            = ARB_EXT;
							end
						end
						ARB_EXT: begin
							// the agent keeps the grant until it drops its request
							if (sReq[st_r.holder] == PIN_IDLE) begin
								st_nxt.gntOut = '1;
								st_nxt.arb    = ARB_IDLE;
							end
						end
						ARB_OWN: begin
							if (!userBusReq) begin
								st_nxt.own = 1'b0;
								st_nxt.arb = ARB_IDLE;
							end
						end
						default: begin
							st_nxt.arb = ARB_IDLE;
						end
					endcase
				end
				MODE_HOST_EXT: begin
					st_nxt.reqOut          = '1;
					st_nxt.reqOut[OWN_REQ] = userBusReq ? PIN_ACTIVE : PIN_IDLE;
					st_nxt.reqOe           = '1;
					st_nxt.gntOut          = '1;
					st_nxt.gntOe           = '1;
					st_nxt.gntOe[OWN_REQ]  = 1'b0;
					st_nxt.own             = (sGnt[OWN_REQ] == PIN_ACTIVE);
					st_nxt.cfgSel          = 1'b0;
				end
				MODE_SATELLITE: begin
					st_nxt.reqOut              = '1;
					st_nxt.reqOut[OWN_REQ]     = userBusReq ? PIN_ACTIVE : PIN_IDLE;
					st_nxt.reqOe               = '1;
					st_nxt.reqOe[CFG_SEL_REQ]  = 1'b0;
					st_nxt.gntOut              = '1;
					st_nxt.gntOe               = '1;
					st_nxt.gntOe[OWN_REQ]      = 1'b0;
					st_nxt.own                 = (sGnt[OWN_REQ] == PIN_ACTIVE);
					st_nxt.cfgSel              = sReq[CFG_SEL_REQ];
				end
				default: begin
					st_nxt.mode = MODE_SATELLITE;
				end
			endcase
		end
		// reset: straps are caught here and nowhere else, so the role stays put on a live bus
		if (srst) begin
			st_nxt          = '0;
			st_nxt.mode     = sHost ? (sArb ? MODE_HOST_INT : MODE_HOST_EXT) : MODE_SATELLITE;
			st_nxt.arb      = ARB_IDLE;
			{st_nxt.clkPrev, st_nxt.rstPrev, st_nxt.perrOut, st_nxt.serrOut, st_nxt.stopOut} = '1;
			{st_nxt.trdyOut, st_nxt.irdyOut, st_nxt.frameOut, st_nxt.reqOut, st_nxt.gntOut}  = '1;
			st_nxt.rstOut   = PIN_ACTIVE; // host holds the bus in reset with the device
			st_nxt.rstOe    = sHost;
		end
	end

	// register the state
	always_ff @(posedge clk) begin
		st_r <= st_nxt;
	end

	// all outputs straight from the state
	assign {busAddrDataOut, busAddrDataOe, busParityOut} = {st_r.adOut, st_r.adOe, st_r.parOut};
	assign {busParityOe, parityErrorNOut, parityErrorNOe} = {st_r.parOe, st_r.perrOut, st_r.perrOe};
	assign {busRequestNOut, busRequestNOe, busGrantNOut} = {st_r.reqOut, st_r.reqOe, st_r.gntOut};
	assign {busGrantNOe, busResetNOut, busResetNOe} = {st_r.gntOe, st_r.rstOut, st_r.rstOe};
	assign {systemErrorNOut, systemErrorNOe, targetStopNOut} = {st_r.serrOut, st_r.serrOe, st_r.stopOut};
	assign {targetStopNOe, targetReadyNOut, targetReadyNOe} = {st_r.stopOe, st_r.trdyOut, st_r.trdyOe};
	assign {initiatorReadyNOut, initiatorReadyNOe, rxAddrData} = {st_r.irdyOut, st_r.irdyOe, st_r.rxWord};
	assign {transactionFrameNOut, transactionFrameNOe, busEdge} = {st_r.frameOut, st_r.frameOe, st_r.edgeOut};
	assign {parityErrorSeen, systemErrorSeen, warmReset} = {st_r.perrSeen, st_r.serrSeen, st_r.warm};
	assign {ownGrant, configSelect, lockActive} = {st_r.own, st_r.cfgSel, st_r.lock};
	assign busMode = st_r.mode;

endmodule : pci_bus_signal_layer

// >>> pkg/pci_sig_pkg.sv
// shared constants and types of the pci pin signalling layer
package pci_sig_pkg;

	localparam int   AD_W             = 32;   // multiplexed address/data width
	localparam int   REQ_W            = 4;    // request and grant pin count
	localparam int   OWN_REQ          = 0;    // request pin the device drives for itself
	localparam int   CFG_SEL_REQ      = 1;    // request pin that turns into config select
	localparam int   PERR_DELAY_EDGES = 2;    // bus clocks from received data to parity error
	localparam logic PIN_IDLE         = 1'b1; // deasserted level of every active low pin
	localparam logic PIN_ACTIVE       = 1'b0; // asserted level of every active low pin

	// bus role, fixed by the straps at reset
	typedef enum logic [1:0] {
		MODE_HOST_INT,
		MODE_HOST_EXT,
		MODE_SATELLITE
	} bus_mode_e;

	// internal arbiter states
	typedef enum logic [1:0] {
		ARB_IDLE,
		ARB_EXT,
		ARB_OWN
	} arb_state_e;

endpackage : pci_sig_pkg

// >>> rtl/pin_sync.sv
// two flip-flop synchroniser for a group of pins
`timescale 1ns/100ps
module pin_sync #(
	parameter int         W       = 1,       // number of pins
	parameter logic [W-1:0] RST_VAL = '1     // value meant for reset, unused since the stages have no reset
) (
	input  wire logic         clk,
	input  wire logic         srst,
	input  wire logic [W-1:0] pinIn,
	output logic      [W-1:0] pinSync
);

	// both stages in one word; stage1 is read only by stage2
	typedef struct packed {
		logic [W-1:0] stage1; // metastability catcher
		logic [W-1:0] stage2; // safe to use
	} sync_s;

	sync_s st_r;  // registered state
	sync_s st_nxt; // next state

	initial begin
		if (W < 1) $error("pin_sync needs at least one pin");
	end

	// shift the pins through two stages; no reset, so straps are settled when the role is caught
	always_comb begin
		st_nxt        = st_r;
		st_nxt.stage1 = pinIn;
		st_nxt.stage2 = st_r.stage1;
	end

	// register the state
	always_ff @(posedge clk) begin
		st_r <= st_nxt;
	end

	assign pinSync = st_r.stage2;

endmodule : pin_sync

// >>> rtl/parity_check.sv
// even parity checker for received address and data phases
`timescale 1ns/100ps
module parity_check
	import pci_sig_pkg::*;
#(
	parameter int DELAY = PERR_DELAY_EDGES // bus clocks from data to error report
) (
	input  wire logic            clk,
	input  wire logic            srst,
	input  wire logic            busEdge,    // one pulse per bus clock rising edge
	input  wire logic [AD_W-1:0] rxAddrData, // sampled bus word
	input  wire logic            rxParity,   // sampled parity pin
	input  wire logic            capture,    // this edge holds a phase the device receives
	input  wire logic            sysClass,   // phase errors go to system error, not parity error
	output logic                 perrDue,    // drive parity error after this edge
	output logic                 serrDue     // drive system error after this edge
);

	// one phase in flight; parity of a phase arrives one edge after its data
	typedef struct packed {
		logic [AD_W-1:0] word;     // held data of the pending phase
		logic            isSys;    // pending phase reports on system error
		logic [1:0]      countdown; // edges until the parity pin is due
	} chk_s;

	chk_s st_r;  // registered state
	chk_s st_nxt; // next state
	logic mismatch; // even parity broken for the pending phase

	initial begin
		if (DELAY != 2) $error("parity_check only serves a two clock report delay");
	end

	// parity is sampled at the edge after the data, the error drives in the clock after that
	assign mismatch = (st_r.countdown == 2'(DELAY - 1)) && ((^st_r.word) != rxParity);
	assign perrDue  = busEdge && mismatch && !st_r.isSys;
	assign serrDue  = busEdge && mismatch && st_r.isSys;

	// capture a new phase, otherwise count down
	always_comb begin
		st_nxt = st_r;
		if (busEdge) begin
			if (capture) begin
				// a back to back phase overwrites only after the old one was compared
				st_nxt.word      = rxAddrData;
				st_nxt.isSys     = sysClass;
				st_nxt.countdown = 2'(DELAY - 1);
			end else if (st_r.countdown != 2'h0) begin
				st_nxt.countdown = st_r.countdown - 2'h1;
			end
		end
		if (srst) begin
			st_nxt = '0;
		end
	end

	// register the state
	always_ff @(posedge clk) begin
		st_r <= st_nxt;
	end

endmodule : parity_check

// >>> tb/pci_far_agent.sv
// far-side pci agent: bus clock source and remote driver of address/data and parity
`timescale 1ns/100ps
module pci_far_agent
	import pci_sig_pkg::*;
(
	output logic                busClk,
	output logic                busParityIn,
	output logic [AD_W-1:0]     busAddrDataIn,
	input  wire logic           farDrive, badPar, busAddrDataOe, busParityOut, busParityOe,
	input  wire logic [AD_W-1:0] farWord, busAddrDataOut
);
	logic [AD_W-1:0] ad, wS;               // word on the pins, word staged at the rising edge
	logic adOn, adBad, par, parOn, dS, bS; // drive flags and bad parity request
	// free-running bus clock, phase unrelated to clk
	initial begin
		{busClk, ad, wS, adOn, adBad, par, parOn, dS, bS} = '0;
		#37;
		forever #400 busClk = ~busClk;
	end
	// requests are taken at the rising edge
	always @(posedge busClk) {wS, dS, bS} <= {farWord, farDrive, badPar};
	// pins move at the falling edge so they stay steady wherever the device samples
	always @(negedge busClk) begin
		parOn <= adOn;
		par   <= ^ad ^ adBad;
		{ad, adOn, adBad} <= {wS, dS, bS};
	end
	// released lines show a changing pattern, never the last value
	assign busAddrDataIn = busAddrDataOe ? busAddrDataOut : adOn ? ad : ~ad;
	assign busParityIn   = busParityOe ? busParityOut : parOn ? par : busClk;
endmodule : pci_far_agent

// >>> tb/pci_sig_sva.sv
// assertion checker for the pci pin signalling layer
`timescale 1ns/100ps
module pci_sig_sva
	import pci_sig_pkg::*;
(
	input wire logic             clk, srst, busEdge, busAddrDataOe, busParityIn, busParityOut, busParityOe,
	input wire logic             parityErrorNOut, parityErrorNOe, busResetNIn, busResetNOe, systemErrorNOut,
	input wire logic             systemErrorNOe, userAdDrive, userRxData, userAddrCheck, userSpecialCycle,
	input wire logic             userSysErr, userBusReq, warmReset,
	input wire logic [AD_W-1:0]  busAddrDataOut, userAdOut, rxAddrData,
	input wire logic [REQ_W-1:0] busRequestNOut, busRequestNOe, busGrantNOut, busGrantNOe,
	input wire bus_mode_e        busMode
);
	logic [AD_W-1:0] adW_r, rxW_r;  // word driven and word received at the last bus edge
	logic adOe_r, rxOn_r, rxSys_r;  // kind of the last phase
	wire parBad = rxOn_r && (^rxW_r != busParityIn); // parity of the last received phase is wrong
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// keep the last phase so its parity can be judged one bus clock later
	always_ff @(posedge clk) begin
		if (srst) begin
			{adOe_r, rxOn_r, rxSys_r} <= 3'h0;
		end else if (busEdge) begin
			{adOe_r, adW_r, rxW_r} <= {busAddrDataOe, busAddrDataOut, rxAddrData};
			rxOn_r  <= $past(userRxData, 2) | $past(userAddrCheck, 2);
			rxSys_r <= $past(userAddrCheck, 2) | $past(userSpecialCycle, 2);
		end
	end
	sequence s_rst_fall;
		(busMode == MODE_SATELLITE) && $fell(busResetNIn);
	endsequence
	a_ad_drive:
		assert property (busEdge |-> busAddrDataOe == $past(userAdDrive, 2) && (!busAddrDataOe ||
			busAddrDataOut == $past(userAdOut, 2))) else $error("bus word not driven as asked");
	a_par_even:
		assert property (busEdge |-> busParityOe == adOe_r && (!adOe_r || busParityOut == ^adW_r))
			else $error("sent parity wrong");
	a_perr_time:
		assert property (busEdge |-> (parityErrorNOe && !parityErrorNOut) == (parBad && !rxSys_r))
			else $error("parity error timing wrong");
	a_serr_cause:
		assert property (busEdge |-> systemErrorNOe == ((parBad && rxSys_r) || $past(userSysErr, 2)))
			else $error("system error cause wrong");
	a_serr_drain:
		assert property (systemErrorNOe |-> !systemErrorNOut) else $error("system error driven high");
	a_req_inputs:
		assert property (busEdge && busMode == MODE_HOST_INT |-> busRequestNOe == 4'h0)
			else $error("request pins driven with internal arbiter");
	a_req_roles:
		assert property (busEdge && busMode != MODE_HOST_INT |-> busRequestNOe ==
			((busMode == MODE_SATELLITE) ? 4'hD : 4'hF) && busRequestNOut[3:2] == 2'h3 &&
			(busMode == MODE_SATELLITE || busRequestNOut[1]) && busRequestNOut[0] == !$past(userBusReq, 2) &&
			busGrantNOe == 4'hE && busGrantNOut[3:1] == 3'h7) else $error("request or grant role wrong");
	a_grant_one:
		assert property ($onehot0(busGrantNOe & ~busGrantNOut)) else $error("more than one grant");
	a_host_rst:
		assert property (busMode != MODE_SATELLITE |-> busResetNOe) else $error("host not driving bus reset");
	a_warm_rst:
		assert property (s_rst_fall |-> ##[1:5] warmReset) else $error("no warm reset");
	a_mode_hold:
		assert property ($stable(busMode)) else $error("mode changed outside reset");
endmodule : pci_sig_sva
bind pci_bus_signal_layer pci_sig_sva u_pci_sig_sva (.*);

// >>> tb/tb_top.sv
// self-checking bench for the pci pin signalling layer
`timescale 1ns/100ps
module tb_top;
	import pci_sig_pkg::*;
	typedef struct {logic [AD_W-1:0] w; logic [1:0] cls; logic bad;} row_t; // cls 0 data 1 addr 2 special 3 send
	logic clk, srst, hostModeStrap, intArbiterStrap, farDrive, badPar, rstDrv, exclusiveLockNIn, seen;
	logic userAdDrive, userRxData, userAddrCheck, userSpecialCycle, userSysErr, userMasterActive, userFrameAssert;
	logic userIrdyAssert, userTargetActive, userTrdyAssert, userStopAssert, userBusReq, userBusReset;
	logic busClk, busParityIn, busParityOut, busParityOe, parityErrorNIn, parityErrorNOut, parityErrorNOe;
	logic busResetNIn, busResetNOut, busResetNOe, systemErrorNIn, systemErrorNOut, systemErrorNOe;
	logic targetStopNIn, targetStopNOut, targetStopNOe, targetReadyNIn, targetReadyNOut, targetReadyNOe;
	logic initiatorReadyNIn, initiatorReadyNOut, initiatorReadyNOe, transactionFrameNIn, transactionFrameNOut;
	logic transactionFrameNOe, busAddrDataOe, busEdge, parityErrorSeen, systemErrorSeen, warmReset, ownGrant;
	logic configSelect, lockActive;
	logic [AD_W-1:0]  busAddrDataIn, busAddrDataOut, userAdOut, rxAddrData, farWord;
	logic [REQ_W-1:0] busRequestNIn, busRequestNOut, busRequestNOe, busGrantNIn, busGrantNOut, busGrantNOe;
	logic [REQ_W-1:0] reqDrv, gntDrv; // far agents on request and grant pins
	bus_mode_e        busMode;
	int               errCount = 0, nChecks = 0;
	row_t rows [7] = '{'{32'h0000_0000, 2'h0, 1'h0}, '{32'hFFFF_FFFF, 2'h0, 1'h1}, '{32'h8000_0001, 2'h1, 1'h1},
		'{32'h1234_5678, 2'h2, 1'h1}, '{32'hA5A5_A5A4, 2'h1, 1'h0}, '{32'h0000_0001, 2'h3, 1'h0},
		'{32'hFFFF_FFFE, 2'h3, 1'h0}};
	// shared lines with pull-ups read high when nobody drives
	assign {parityErrorNIn, systemErrorNIn, targetStopNIn, targetReadyNIn, initiatorReadyNIn, transactionFrameNIn} =
		~{parityErrorNOe, systemErrorNOe, targetStopNOe, targetReadyNOe, initiatorReadyNOe, transactionFrameNOe} |
		{parityErrorNOut, systemErrorNOut, targetStopNOut, targetReadyNOut, initiatorReadyNOut, transactionFrameNOut};
	assign busRequestNIn       = (busRequestNOe & busRequestNOut) | (~busRequestNOe & reqDrv);
	assign busGrantNIn         = (busGrantNOe & busGrantNOut) | (~busGrantNOe & gntDrv);
	assign busResetNIn         = busResetNOe ? busResetNOut : rstDrv;
	pci_bus_signal_layer u_pci_bus_signal_layer (.*);
	pci_far_agent u_pci_far_agent (.*);
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	// cut a hang short, far beyond the expected run length
	initial begin
		#2000000;
		errCount++;
		conclude();
	end
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		nChecks++;
		if (got !== exp) begin
			errCount++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// wait for the next bus edge seen by the design, then step just past the clock edge
	task automatic edgeWait;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (busEdge !== 1'h1 && n < 40);
		if (n >= 40) chk(40'h0, 40'h1);
		#10;
	endtask : edgeWait
	task automatic doReset(input logic h, input logic a, input bus_mode_e m);
		@(posedge clk);
		#10;
		{srst, hostModeStrap, intArbiterStrap} = {1'h1, h, a};
		repeat (5) @(posedge clk);
		if (h) chk({busResetNOe, busResetNOut}, 2'h2);
		#10 srst = 1'h0;
		chk(busMode, m);
	endtask : doReset
	task automatic conclude;
		$display("checks %0d mismatches %0d", nChecks, errCount);
		if (errCount == 0 && nChecks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : conclude
	initial begin
		{srst, hostModeStrap, intArbiterStrap, rstDrv, exclusiveLockNIn, farDrive, badPar} = 7'h7C;
		{userAdDrive, userRxData, userAddrCheck, userSpecialCycle, userSysErr, userMasterActive} = 6'h00;
		{userFrameAssert, userIrdyAssert, userTargetActive, userTrdyAssert, userStopAssert} = 5'h00;
		{userBusReq, userBusReset, farWord, userAdOut, reqDrv, gntDrv} = {66'h0, 8'hFF};
		doReset(1'h1, 1'h1, MODE_HOST_INT);
		// table: receive rows check parity judgement, send rows check driven word and parity
		foreach (rows[i]) begin
			edgeWait;
			if (rows[i].cls == 2'h3) begin
				{userAdDrive, userAdOut} = {1'h1, rows[i].w};
				edgeWait;
				userAdDrive = 1'h0;
				chk({busAddrDataOe, busAddrDataOut}, {1'h1, rows[i].w});
				edgeWait;
				chk({busParityOe, busParityOut}, {1'h1, ^rows[i].w});
			end else begin
				{farWord, farDrive, badPar} = {rows[i].w, 1'h1, rows[i].bad};
				edgeWait;
				farDrive = 1'h0;
				{userRxData, userAddrCheck} = {rows[i].cls != 2'h1, rows[i].cls == 2'h1};
				userSpecialCycle = rows[i].cls == 2'h2;
				edgeWait;
				{userRxData, userAddrCheck, userSpecialCycle} = 3'h0;
				chk(rxAddrData, rows[i].w);
				edgeWait;
				chk({parityErrorNOe & ~parityErrorNOut, systemErrorNOe & ~systemErrorNOut},
					{rows[i].bad & (rows[i].cls == 2'h0), rows[i].bad & (rows[i].cls != 2'h0)});
			end
		end
		$display("parity table done");
		{userMasterActive, userFrameAssert, userIrdyAssert, userTargetActive, userTrdyAssert} = 5'h1F;
		{userStopAssert, userSysErr} = 2'h3;
		edgeWait;
		{userFrameAssert, userStopAssert, userSysErr} = 3'h0;
		edgeWait;
		chk({transactionFrameNOut, initiatorReadyNOut, targetReadyNOut, targetStopNOut, transactionFrameNOe,
			initiatorReadyNOe, targetReadyNOe, targetStopNOe, systemErrorNOe, systemErrorNOut}, 10'h27D);
		edgeWait;
		chk({transactionFrameNOe, transactionFrameNOut, initiatorReadyNOut, systemErrorNOe}, 4'hC);
		{userMasterActive, userIrdyAssert, userTargetActive, userTrdyAssert} = 4'h0;
		exclusiveLockNIn = 1'h0;
		repeat (2) edgeWait;
		chk(lockActive, 1'h1);
		{exclusiveLockNIn, reqDrv} = {1'h1, 4'h9};
		repeat (3) edgeWait;
		chk({busRequestNOe, busGrantNOe & ~busGrantNOut}, 8'h02);
		{reqDrv, userBusReq} = {4'hF, 1'h1};
		repeat (4) edgeWait;
		chk({ownGrant, busGrantNOe & ~busGrantNOut}, 5'h10);
		{userBusReq, userBusReset} = 2'h1;
		edgeWait;
		userBusReset = 1'h0;
		chk({busResetNOe, busResetNOut}, 2'h2);
		edgeWait;
		chk({busResetNOe, busResetNOut}, 2'h3);
		$display("host internal arbiter done");
		doReset(1'h1, 1'h0, MODE_HOST_EXT);
		{gntDrv, userBusReq} = {4'hE, 1'h1};
		repeat (3) edgeWait;
		chk({busRequestNOe, busRequestNOut, busGrantNOe, busGrantNOut[3:1], ownGrant}, 16'hFEEF);
		{gntDrv, userBusReq} = {4'hF, 1'h0};
		$display("host external arbiter done");
		doReset(1'h0, 1'h0, MODE_SATELLITE);
		repeat (2) edgeWait;
		chk({busRequestNOe, configSelect}, 5'h1B);
		{rstDrv, seen} = 2'h0;
		repeat (10) begin
			@(posedge clk);
			seen |= (warmReset === 1'h1);
		end
		chk(seen, 1'h1);
		$display("satellite done");
		conclude();
	end
endmodule : tb_top
